/* File: hdl/rtc_regs.v */
// Rate threshold configuration, debounce count, temperature and primary
// control registers, with the per-axis rate threshold debounce engine.
// Assumes a same-clock register port (address, write, read strobes) and
// a same-clock sample source for the three axis rates and raw temperature.
`timescale 1ns/1ps
`include "rtc_map.vh"

// Operation
// - Debounce mode one clears the counter whenever rate is below threshold.
// - Debounce mode zero decrements counter each sample below threshold.
// - Threshold in LSBs is field plus one, times 256.
// - Detector state resets on Standby or Ready going to Active.
// - Debounce counter also returns to zero on that transition.
// - Debounce count sets samples above threshold before flag; resets to one.
// - Counter advances once per output sample period.
// - Temperature reads as 8-bit two's complement, 1 degree per LSB.
// - Temperature trim applies only while Active and measuring.
// - Software reset bit returns registers to defaults.
// - Software reset bit clears itself once reset is done.
// - Self-test bit forces an output change without rotation.
// - Data rate field selects the sample rate used by debounce.
// - Bit 1 selects Active, bit 0 selects Ready.
// - Active wins over Ready; both zero means Standby.
// - Rate codes map 800 Hz down to 12.5 Hz; code 7 is 12.5 Hz.
// - Axis flag sets after count samples above, clears after count below in mode zero, after one below in mode one.
module rtc_regs (
    input  wire        clock_i,
    input  wire        reset_i,
    input  wire [7:0]  reg_addr_i,
    input  wire        reg_write_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_read_i,
    output reg  [7:0]  reg_rdata_o,
    input  wire [47:0] axis_rate_i,
    input  wire [7:0]  temp_raw_i,
    input  wire [7:0]  temp_trim_i,
    output wire        sample_tick_o,
    output wire        acquire_o,
    output wire        self_test_o,
    output wire [15:0] self_test_delta_o,
    output wire [2:0]  rate_event_o,
    output wire [2:0]  rate_negative_o,
    output wire [1:0]  op_mode_o
);
    // One-hot operating modes
    localparam [2:0] MODE_STANDBY = 3'b001;
    localparam [2:0] MODE_READY   = 3'b010;
    localparam [2:0] MODE_ACTIVE  = 3'b100;

    reg  [7:0]  rate_threshold_config;
    reg  [7:0]  rate_debounce_count;
    reg  [7:0]  temperature_value;
    reg  [7:0]  primary_control;
    reg  [2:0]  mode;
    reg  [2:0]  next_mode;
    reg         soft_reset_pending;
    wire [2:0]  event_flag;
    wire [2:0]  negative_flag;
    wire        entering_active;
    wire [15:0] threshold_lsb;
    wire        debounce_mode;

    // Decode the mode bits, Active over Ready
    function [2:0] rtc_decode_mode;
        input [7:0] ctrl;
        begin
            if (ctrl[`RTC_BIT_ACTIVE])
                rtc_decode_mode = MODE_ACTIVE;
            else if (ctrl[`RTC_BIT_READY])
                rtc_decode_mode = MODE_READY;
            else
                rtc_decode_mode = MODE_STANDBY;
        end
    endfunction

    // Absolute value of a signed 16-bit sample
    function [15:0] rtc_abs;
        input [15:0] value;
        begin
            rtc_abs = value[15] ? (16'h0000 - value) : value;
        end
    endfunction

    always @* begin
        next_mode = rtc_decode_mode(primary_control);
    end

    assign entering_active = (next_mode == MODE_ACTIVE) && (mode != MODE_ACTIVE);
    // Field+1 times 256, as a 16-bit magnitude
    assign threshold_lsb   = {1'b0, rate_threshold_config[`RTC_THS_MSB:0], 8'h00}
                             + 16'h0100;
    assign debounce_mode   = rate_threshold_config[`RTC_BIT_DEBOUNCE_MODE];

    // Mode register follows the control bits one cycle later
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i)
            mode <= MODE_STANDBY;
        else begin
            case (next_mode)
                MODE_STANDBY: mode <= MODE_STANDBY;
                MODE_READY:   mode <= MODE_READY;
                MODE_ACTIVE:  mode <= MODE_ACTIVE;
                default:      mode <= MODE_STANDBY;
            endcase
        end
    end

    // Sample tick runs only while Active
    rtc_rate_divider u_divider (
        .clock_i           (clock_i),
        .reset_i           (reset_i),
        .run_i             (next_mode == MODE_ACTIVE),
        .clear_i           (entering_active | soft_reset_pending),
        .data_rate_field_i (primary_control[`RTC_DR_MSB:`RTC_DR_LSB]),
        .tick_o            (sample_tick_o)
    );

    // Register writes and software reset
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rate_threshold_config <= `RTC_RST_THRESHOLD;
            rate_debounce_count   <= `RTC_RST_DEBOUNCE;
            primary_control       <= `RTC_RST_CONTROL;
            soft_reset_pending    <= 1'b0;
        end else if (soft_reset_pending) begin
            rate_threshold_config <= `RTC_RST_THRESHOLD;
            rate_debounce_count   <= `RTC_RST_DEBOUNCE;
            primary_control       <= `RTC_RST_CONTROL;
            soft_reset_pending    <= 1'b0;
        end else if (reg_write_i) begin
            case (reg_addr_i)
                `RTC_OFS_THRESHOLD: rate_threshold_config <= reg_wdata_i;
                `RTC_OFS_DEBOUNCE:  rate_debounce_count   <= reg_wdata_i;
                `RTC_OFS_CONTROL: begin
                    primary_control    <= reg_wdata_i;
                    soft_reset_pending <= reg_wdata_i[`RTC_BIT_SW_RESET];
                end
                default: ;
            endcase
        end
    end

    // Temperature: trimmed only while Active, raw otherwise
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i)
            temperature_value <= `RTC_RST_TEMPERATURE;
        else if (soft_reset_pending)
            temperature_value <= `RTC_RST_TEMPERATURE;
        else if (mode == MODE_ACTIVE)
            temperature_value <= temp_raw_i + temp_trim_i;
        else
            temperature_value <= temp_raw_i;
    end

    // Per-axis debounce engine, each axis owns its counter and flags
    genvar axis;
    generate
        for (axis = 0; axis < 3; axis = axis + 1) begin : g_axis
            wire [15:0] sample;
            wire        above;
            reg  [7:0]  counter;
            reg  [7:0]  next_counter;
            reg         flag;
            reg         next_flag;
            reg         negative;

            // Strictly greater than the threshold counts as above
            assign sample = axis_rate_i[axis*16 +: 16];
            assign above  = rtc_abs(sample) > threshold_lsb;

            // Counter and flag update for one output sample
            always @* begin
                next_counter = counter;
                next_flag    = flag;
                if (above) begin
                    // Count up, hold at the programmed count
                    if (counter < rate_debounce_count)
                        next_counter = counter + 8'h01;
                    else
                        next_counter = rate_debounce_count;
                    if (counter + 8'h01 >= rate_debounce_count)
                        next_flag = 1'b1;
                end else if (debounce_mode) begin
                    next_counter = 8'h00;
                    next_flag    = 1'b0;
                end else begin
                    // Count down, never below zero
                    if (counter != 8'h00)
                        next_counter = counter - 8'h01;
                    if (counter <= 8'h01)
                        next_flag = 1'b0;
                end
            end

            // State cleared on entry to Active and on software reset
            always @(posedge clock_i or posedge reset_i) begin
                if (reset_i) begin
                    counter  <= 8'h00;
                    flag     <= 1'b0;
                    negative <= 1'b0;
                end else if (entering_active || soft_reset_pending) begin
                    counter  <= 8'h00;
                    flag     <= 1'b0;
                    negative <= 1'b0;
                end else if (sample_tick_o) begin
                    counter  <= next_counter;
                    flag     <= next_flag;
                    negative <= sample[15];
                end
            end

            // Single driver per flag bit
            assign event_flag[axis]    = flag;
            assign negative_flag[axis] = negative;
        end
    endgenerate

    // Register read mux, reset bit shows pending state
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i)
            reg_rdata_o <= 8'h00;
        else if (reg_read_i) begin
            case (reg_addr_i)
                `RTC_OFS_THRESHOLD:   reg_rdata_o <= rate_threshold_config;
                `RTC_OFS_DEBOUNCE:    reg_rdata_o <= rate_debounce_count;
                `RTC_OFS_TEMPERATURE: reg_rdata_o <= temperature_value;
                `RTC_OFS_CONTROL:     reg_rdata_o <= primary_control;
                default:              reg_rdata_o <= 8'h00;
            endcase
        end
    end

    assign acquire_o         = (mode == MODE_ACTIVE);
    assign self_test_o       = primary_control[`RTC_BIT_SELF_TEST] & acquire_o;
    assign self_test_delta_o = self_test_o ? `RTC_SELF_TEST_DELTA : 16'h0000;
    assign rate_event_o      = event_flag;
    assign rate_negative_o   = negative_flag;
    assign op_mode_o         = {mode == MODE_ACTIVE, mode == MODE_READY};
endmodule // rtc_regs

/* File: hdl/rtc_map.vh */
// Register offsets, field positions, reset values and timing counts
// for the rate threshold and control register bank.
// Assumes a 50 MHz system clock.
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

`define RTC_OFS_THRESHOLD      8'h10
`define RTC_OFS_DEBOUNCE       8'h11
`define RTC_OFS_TEMPERATURE    8'h12
`define RTC_OFS_CONTROL        8'h13

`define RTC_RST_THRESHOLD      8'h00
`define RTC_RST_DEBOUNCE       8'h01
`define RTC_RST_TEMPERATURE    8'h00
`define RTC_RST_CONTROL        8'h00

`define RTC_BIT_DEBOUNCE_MODE  7
`define RTC_THS_MSB            6
`define RTC_THS_SHIFT          8
`define RTC_BIT_SW_RESET       6
`define RTC_BIT_SELF_TEST      5
`define RTC_DR_MSB             4
`define RTC_DR_LSB             2
`define RTC_BIT_ACTIVE         1
`define RTC_BIT_READY          0

`define RTC_CLOCK_HZ           50000000
// Sample rate in tenths of Hz, 800 Hz down to 12.5 Hz
`define RTC_RATE0_DHZ          8000
`define RTC_RATE1_DHZ          4000
`define RTC_RATE2_DHZ          2000
`define RTC_RATE3_DHZ          1000
`define RTC_RATE4_DHZ          500
`define RTC_RATE5_DHZ          250
`define RTC_RATE6_DHZ          125
`define RTC_CYC(dhz)           ((`RTC_CLOCK_HZ * 10) / (dhz))
// Self-test output offset added to each sample, in LSBs
`define RTC_SELF_TEST_DELTA    16'h0400

`endif

/* File: hdl/rtc_rate_divider.v */
// Output sample rate divider: one-cycle tick at the selected rate.
// Assumes a 50 MHz clock; restarts on clear or while not running, but not when the rate code changes.
`timescale 1ns/1ps
module rtc_rate_divider (
    input  wire        clock_i,
    input  wire        reset_i,
    input  wire        run_i,
    input  wire        clear_i,
    input  wire [2:0]  data_rate_field_i,
    output reg         tick_o
);
    reg  [22:0] count;
    reg  [22:0] limit;
    reg  [31:0] period;

    // Period in clock cycles for each rate code, code 7 repeats 12.5 Hz
    always @* begin
        case (data_rate_field_i)
            3'h0:    period = `RTC_CYC(`RTC_RATE0_DHZ);
            3'h1:    period = `RTC_CYC(`RTC_RATE1_DHZ);
            3'h2:    period = `RTC_CYC(`RTC_RATE2_DHZ);
            3'h3:    period = `RTC_CYC(`RTC_RATE3_DHZ);
            3'h4:    period = `RTC_CYC(`RTC_RATE4_DHZ);
            3'h5:    period = `RTC_CYC(`RTC_RATE5_DHZ);
            default: period = `RTC_CYC(`RTC_RATE6_DHZ);
        endcase
        // Longest period fits in 23 bits, upper bits dropped on purpose
        limit = period[22:0] - 23'h000001;
    end

    // Free count while acquiring, tick on wrap
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            count  <= 23'h000000;
            tick_o <= 1'b0;
        end else if (clear_i || !run_i) begin
            count  <= 23'h000000;
            tick_o <= 1'b0;
        end else if (count >= limit) begin
            count  <= 23'h000000;
            tick_o <= 1'b1;
        end else begin
            count  <= count + 23'h000001;
            tick_o <= 1'b0;
        end
    end
endmodule // rtc_rate_divider

/* File: tb/rtc_sensor_model.sv */
// Sensor-side stand-in: axis rate samples and raw temperature.
// Assumes the bench picks the scene; values are levels, held steady.
`timescale 1ns/1ps
module rtc_sensor_model (
    input  wire logic        scene_i,
    output logic      [47:0] axis_rate_o,
    output logic      [7:0]  temp_raw_o,
    output logic      [7:0]  temp_trim_o
);
    // Scene 1: X just above 256, Y at -300, Z exactly 256 (not above)
    assign axis_rate_o = scene_i ? {16'h0100, 16'hfed4, 16'h0101} : 48'h0;
    // Raw reading -26, trim +3
    assign temp_raw_o  = 8'he6;
    assign temp_trim_o = 8'h03;
endmodule // rtc_sensor_model

/* File: tb/rtc_regs_assertions.sv */
// Port-level checker for the rate threshold register bank.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
module rtc_regs_assertions (
    input wire logic        clock_i,
    input wire logic        reset_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_write_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_read_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        sample_tick_o,
    input wire logic        acquire_o,
    input wire logic        self_test_o,
    input wire logic [15:0] self_test_delta_o,
    input wire logic [2:0]  rate_event_o,
    input wire logic [1:0]  op_mode_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // Mode, self-test, tick and register port relations
    property p_acq; acquire_o == op_mode_o[1]; endproperty
    property p_st_delta; self_test_o |-> self_test_delta_o == 16'h0400; endproperty
    property p_st_off; !self_test_o |-> self_test_delta_o == 16'h0000; endproperty
    property p_tick; sample_tick_o |-> acquire_o ##1 !sample_tick_o; endproperty
    property p_unmapped; reg_read_i && (reg_addr_i < 8'h10 || reg_addr_i > 8'h13)
        |=> reg_rdata_o == 8'h00; endproperty
    property p_hold; !reg_read_i |=> $stable(reg_rdata_o); endproperty
    property p_mode; reg_write_i && reg_addr_i == 8'h13 && !reg_wdata_i[6]
        && !($past(reg_write_i) && $past(reg_addr_i) == 8'h13 && $past(reg_wdata_i[6]))
        |-> ##2 op_mode_o[1] == $past(reg_wdata_i[1], 2); endproperty
    property p_srst; reg_write_i && reg_addr_i == 8'h13 && reg_wdata_i[6]
        |-> ##[2:4] op_mode_o == 2'b00; endproperty
    property p_evclr; $rose(op_mode_o[1]) |-> ##1 rate_event_o == 3'b000; endproperty
    a_acq: assert property (p_acq) else $error("acquire differs from mode");
    a_st_delta: assert property (p_st_delta) else $error("delta missing");
    a_st_off: assert property (p_st_off) else $error("delta while off");
    a_tick: assert property (p_tick) else $error("bad sample tick");
    a_unmapped: assert property (p_unmapped) else $error("unmapped nonzero");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_mode: assert property (p_mode) else $error("mode not applied");
    a_srst: assert property (p_srst) else $error("soft reset missed");
    a_evclr: assert property (p_evclr) else $error("events not cleared");
    c_tick: cover property (sample_tick_o);
    c_event: cover property (rate_event_o != 3'b000);
    c_st: cover property (self_test_o);
endmodule // rtc_regs_assertions
bind rtc_regs rtc_regs_assertions u_chk (.clock_i(clock_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_write_i(reg_write_i), .reg_wdata_i(reg_wdata_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .sample_tick_o(sample_tick_o),
    .acquire_o(acquire_o), .self_test_o(self_test_o),
    .self_test_delta_o(self_test_delta_o), .rate_event_o(rate_event_o),
    .op_mode_o(op_mode_o));

/* File: tb/rtc_regs_tb.sv */
// Self-checking bench for the rate threshold register bank.
// Assumes 50 MHz clock and single-byte strobe register accesses.
`timescale 1ns/1ps
module rtc_regs_tb;
    logic clock_i = 1'b0, reset_i = 1'b1, reg_write_i = 1'b0, reg_read_i = 1'b0;
    logic scene = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, temp_raw, temp_trim;
    logic [47:0] axis_rate;
    logic sample_tick_o, acquire_o, self_test_o;
    logic [15:0] self_test_delta_o;
    logic [2:0] rate_event_o, rate_negative_o;
    logic [1:0] op_mode_o;
    int n_mismatch = 0, comparisons = 0, i;
    // 20 ns clock
    always #10 clock_i = ~clock_i;
    rtc_sensor_model u_model (.scene_i(scene), .axis_rate_o(axis_rate),
        .temp_raw_o(temp_raw), .temp_trim_o(temp_trim));
    rtc_regs u_dut (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_write_i(reg_write_i), .reg_wdata_i(reg_wdata_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .axis_rate_i(axis_rate), .temp_raw_i(temp_raw),
        .temp_trim_i(temp_trim), .sample_tick_o(sample_tick_o), .acquire_o(acquire_o),
        .self_test_o(self_test_o), .self_test_delta_o(self_test_delta_o),
        .rate_event_o(rate_event_o), .rate_negative_o(rate_negative_o),
        .op_mode_o(op_mode_o));
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i); reg_addr_i = a; reg_wdata_i = d; reg_write_i = 1'b1;
        @(negedge clock_i); reg_write_i = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock_i); reg_addr_i = a; reg_read_i = 1'b1;
        @(negedge clock_i); reg_read_i = 1'b0;
        chk("rdata", {8'h00, e}, {8'h00, reg_rdata_o});
    endtask
    task tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog: one 800 Hz period plus margin
    initial begin
        repeat (90000) @(posedge clock_i);
        n_mismatch++;
        tally_and_finish;
    end
    // Main sequence
    initial begin
        repeat (8) @(negedge clock_i);
        reset_i = 1'b0;
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h01);
        rd(8'h13, 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h12, 8'h55);
        rd(8'h12, 8'he6);
        wr(8'h10, 8'h85);
        wr(8'h11, 8'h07);
        rd(8'h10, 8'h85);
        rd(8'h11, 8'h07);
        wr(8'h13, 8'h01);
        @(negedge clock_i);
        chk("ready", 16'h0001, {14'h0, op_mode_o});
        wr(8'h13, 8'h23);
        @(negedge clock_i);
        chk("active", 16'h0001, {15'h0, op_mode_o[1]});
        chk("selftest", 16'h0400, self_test_delta_o);
        rd(8'h12, 8'he9);
        rd(8'h13, 8'h23);
        wr(8'h13, 8'h43);
        repeat (2) @(negedge clock_i);
        rd(8'h13, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'h11, 8'h01);
        // Threshold 256, count 0, X and Y above, Z on the threshold
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h00);
        scene = 1'b1;
        wr(8'h13, 8'h02);
        @(negedge clock_i);
        chk("event_start", 16'h0000, {13'h0, rate_event_o});
        i = 0;
        while (sample_tick_o !== 1'b1 && i < 70000) begin
            @(negedge clock_i);
            i++;
        end
        chk("period_ok", 16'h0001, {15'h0, (i > 62400 && i < 62600)});
        repeat (2) @(negedge clock_i);
        chk("events", 16'h0003, {13'h0, rate_event_o});
        chk("signs", 16'h0002, {13'h0, rate_negative_o});
        tally_and_finish;
    end
endmodule // rtc_regs_tb
